// ===== dv/crc_host_model.sv
// Host side model: power state, charge source, detection events, control levels.
// Assumes the block samples all of these on the rising edge of sys_clk.
`timescale 1ns/100ps
`default_nettype none

module crc_host_model
	import crc_pkg::*;
(
	input wire logic sys_clk,
	output logic in_active_state,
	output logic charge_valid,
	output logic [CHG_W-1:0] charge_amount,
	output logic attach_event,
	output logic removal_event,
	output logic mode_select_1,
	output logic mode_select_2,
	output logic emulation_enable,
	output logic detect_select,
	output logic port_power_enable
);
	initial begin
		{in_active_state, charge_valid, attach_event, removal_event} = 4'h0;
		{mode_select_1, mode_select_2, emulation_enable, detect_select} = 4'hF;
		port_power_enable = 1'b1;
		charge_amount = 16'hA5A5;
	end

	////////////////////////////////////////////////////////////////////////
	// Amount is scrambled between samples so a stale value never looks valid
	task automatic give(input logic act, input int n, input logic [CHG_W-1:0] amt);
		repeat (n) begin
			@(posedge sys_clk);
			in_active_state <= act;
			charge_valid <= 1'b1;
			charge_amount <= amt;
			@(posedge sys_clk);
			charge_valid <= 1'b0;
			charge_amount <= ~amt;
		end
	endtask

	task automatic replug();
		@(posedge sys_clk);
		removal_event <= 1'b1;
		@(posedge sys_clk);
		removal_event <= 1'b0;
		attach_event <= 1'b1;
		@(posedge sys_clk);
		attach_event <= 1'b0;
	endtask

	task automatic flip_mode();
		@(posedge sys_clk);
		mode_select_1 <= ~mode_select_1;
	endtask

	// Drops port power for one cycle, then restores it
	task automatic toggle_power();
		@(posedge sys_clk);
		port_power_enable <= 1'b0;
		@(posedge sys_clk);
		port_power_enable <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Testbench: register tasks, host model, directed rationing sequences.
// Assumes the block's register map and one-cycle read latency.
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import crc_pkg::*;
	logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
	logic in_active_state, charge_valid, attach_event, removal_event;
	logic mode_select_1, mode_select_2, emulation_enable, detect_select, port_power_enable;
	logic [CHG_W-1:0] charge_amount;
	logic alert_out, alert_oe_n, power_switch_force_open, bypass_force_open;
	logic emulation_remove, sleep_request, reeval_enter_pulse, reeval_resume_pulse;
	logic emulation_restart_pulse;
	int failures = 0, n_tests = 0, n_enter = 0, n_resume = 0, n_restart = 0;
	logic [1:0] act_tab [8] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h3};
	logic [7:0] exp_tab [8] = '{8'h01, 8'h03, 8'h07, 8'h0D, 8'h03, 8'h1D, 8'h07, 8'h01};
	logic [7:0] msk_tab [8] = '{8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h0B, 8'h1F, 8'h0F, 8'h0B};

	crc_host_model crc_host_model_inst (.sys_clk(sys_clk), .in_active_state(in_active_state),
		.charge_valid(charge_valid), .charge_amount(charge_amount),
		.attach_event(attach_event), .removal_event(removal_event),
		.mode_select_1(mode_select_1), .mode_select_2(mode_select_2),
		.emulation_enable(emulation_enable), .detect_select(detect_select),
		.port_power_enable(port_power_enable));

	crc_charge_rationing crc_charge_rationing_inst (.sys_clk(sys_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .in_active_state(in_active_state),
		.charge_valid(charge_valid), .charge_amount(charge_amount),
		.attach_event(attach_event), .removal_event(removal_event),
		.mode_select_1(mode_select_1), .mode_select_2(mode_select_2),
		.emulation_enable(emulation_enable), .detect_select(detect_select),
		.port_power_enable(port_power_enable), .alert_out(alert_out),
		.alert_oe_n(alert_oe_n), .power_switch_force_open(power_switch_force_open),
		.bypass_force_open(bypass_force_open), .emulation_remove(emulation_remove),
		.sleep_request(sleep_request), .reeval_enter_pulse(reeval_enter_pulse),
		.reeval_resume_pulse(reeval_resume_pulse),
		.emulation_restart_pulse(emulation_restart_pulse));

	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	// Pulses last one cycle, so they are counted rather than polled
	always @(posedge sys_clk) begin
		if (reeval_enter_pulse === 1'b1) n_enter++;
		if (reeval_resume_pulse === 1'b1) n_resume++;
		if (emulation_restart_pulse === 1'b1) n_restart++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic ctl(input logic en, input logic rst, input logic [1:0] act);
		wr(OFF_CTRL, {28'h0, act, rst, en});
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		cmp(reg_rdata & m, exp, "register read");
	endtask

	task automatic pins(input logic [7:0] exp, input logic [7:0] m);
		cmp({emulation_remove, sleep_request, power_switch_force_open, ~alert_oe_n, 1'b0}
			& m & 8'h1E, exp & m & 8'h1E, "output pins");
		cmp({bypass_force_open & m[2], alert_out}, {exp[2] & m[2], 1'b0}, "bypass and alert data");
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#200000;
		failures++;
		close_out();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		chk(OFF_CTRL, 32'h4, '1);
		chk(OFF_LIMIT, 32'hFFFF, '1);
		chk(8'h10, 32'h0, '1);
		cmp(alert_oe_n, 1'b1, "alert idle");
		pins(8'h00, 8'h1F);
		$display("test reset done");
		wr(OFF_LIMIT, 32'd20);
		ctl(1'b1, 1'b0, ACT_IGNORE);
		crc_host_model_inst.give(1'b0, 2, 16'd5);
		chk(OFF_ACCUM, 32'h0, '1);
		crc_host_model_inst.give(1'b1, 3, 16'd5);
		crc_host_model_inst.replug();
		repeat (2) @(posedge sys_clk);
		cmp(n_restart, 1, "restart count");
		chk(OFF_ACCUM, 32'd15, '1);
		ctl(1'b1, 1'b0, ACT_REPORT);
		chk(OFF_STATUS, 32'h0, '1);
		chk(OFF_ACCUM, 32'd15, '1);
		crc_host_model_inst.give(1'b1, 1, 16'd5);
		repeat (4) @(posedge sys_clk);
		cmp(alert_oe_n, 1'b0, "alert on reach");
		chk(OFF_STATUS, 32'h3, '1);
		$display("test accumulate done");
		for (int i = 0; i < 8; i++) begin
			ctl(1'b1, 1'b0, act_tab[i]);
			chk(OFF_STATUS, exp_tab[i], msk_tab[i]);
			pins(exp_tab[i], msk_tab[i]);
		end
		chk(OFF_ACCUM, 32'd20, '1);
		cmp(n_resume, 3, "resume count");
		cmp(n_enter, 0, "enter count");
		$display("test action change done");
		ctl(1'b1, 1'b1, ACT_REPORT);
		chk(OFF_ACCUM, 32'h0, '1);
		chk(OFF_STATUS, 32'h0, 32'h3);
		chk(OFF_CTRL, 32'h1, '1);
		crc_host_model_inst.give(1'b1, 1, 16'd7);
		chk(OFF_ACCUM, 32'd7, '1);
		ctl(1'b0, 1'b0, ACT_REPORT);
		chk(OFF_ACCUM, 32'h0, '1);
		$display("test reset request done");
		ctl(1'b1, 1'b0, ACT_RPT_DISC);
		crc_host_model_inst.give(1'b1, 1, 16'd30);
		repeat (4) @(posedge sys_clk);
		chk(OFF_STATUS, 32'h17, '1);
		pins(8'h17, 8'h1F);
		ctl(1'b1, 1'b1, ACT_RPT_DISC);
		chk(OFF_STATUS, 32'h0, '1);
		cmp(n_resume, 4, "resume after reset");
		pins(8'h00, 8'h1F);
		crc_host_model_inst.give(1'b1, 1, 16'd30);
		repeat (4) @(posedge sys_clk);
		chk(OFF_STATUS, 32'h17, '1);
		crc_host_model_inst.flip_mode();
		ctl(1'b0, 1'b0, ACT_RPT_DISC);
		chk(OFF_STATUS, 32'h0, 32'h3);
		cmp(n_enter, 1, "enter count");
		cmp(n_restart, 2, "restart count");
		crc_host_model_inst.toggle_power();
		$display("test disable done");
		close_out();
	end
endmodule
`default_nettype wire

// ===== hdl/crc_charge_rationing.sv
// Charge rationing control: accumulates delivered charge, applies the action.
// Assumes synchronous inputs, one-cycle event pulses, and a host on the port.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module crc_charge_rationing
	import crc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic in_active_state,
	input wire logic charge_valid,
	input wire logic [CHG_W-1:0] charge_amount,
	input wire logic attach_event,
	input wire logic removal_event,
	input wire logic mode_select_1,
	input wire logic mode_select_2,
	input wire logic emulation_enable,
	input wire logic detect_select,
	input wire logic port_power_enable,
	output logic alert_out,
	output logic alert_oe_n,
	output logic power_switch_force_open,
	output logic bypass_force_open,
	output logic emulation_remove,
	output logic sleep_request,
	output logic reeval_enter_pulse,
	output logic reeval_resume_pulse,
	output logic emulation_restart_pulse
);

	////////////////////////////////////////////////////////////////////////
	crc_state_t state_q, state_d;
	logic en_q;
	logic rst_req_q;
	logic [1:0] act_q;
	logic [CHG_W-1:0] limit_q;
	logic [CHG_W-1:0] acc_q, acc_d;
	logic [CTRL_W-1:0] snap_q;
	logic removal_seen_q, removal_seen_d;
	logic alert_q, open_q, sleep_q, emu_rm_q;
	logic enter_q, resume_q, restart_q;
	logic [DATA_W-1:0] rdata_q;
	logic reeval;

	////////////////////////////////////////////////////////////////////////
	wire logic ctrl_wr = reg_wr && (reg_addr == OFF_CTRL);
	wire logic limit_wr = reg_wr && (reg_addr == OFF_LIMIT);
	wire logic new_en = reg_wdata[CTRL_EN_BIT];
	wire logic [1:0] new_act = reg_wdata[CTRL_ACT_LSB +: 2];
	wire logic rst_wr = ctrl_wr && reg_wdata[CTRL_RST_BIT];
	wire logic in_idle = (state_q == ST_IDLE);
	wire logic in_count = (state_q == ST_COUNT);
	wire logic in_limit = (state_q == ST_LIMIT);
	wire logic disable_ev = ctrl_wr && !new_en && en_q;
	wire logic act_chg = ctrl_wr && new_en && (new_act != act_q);
	wire logic [1:0] act_d = ctrl_wr ? new_act : act_q;
	wire logic [CTRL_W-1:0] ctrl_vec = {mode_select_1, mode_select_2, emulation_enable,
		detect_select, port_power_enable};
	wire logic ctrl_changed = (ctrl_vec != snap_q);
	wire logic [CHG_W:0] acc_sum = {1'b0, acc_q} + {1'b0, charge_amount};
	wire logic [CHG_W-1:0] acc_sat = acc_sum[CHG_W] ? {CHG_W{1'b1}} : acc_sum[CHG_W-1:0];
	wire logic reached_now = (acc_q >= limit_q);
	wire logic old_disc = (act_q == ACT_RPT_DISC) || (act_q == ACT_DISC_SLEEP);
	wire logic new_disc = (act_d == ACT_RPT_DISC) || (act_d == ACT_DISC_SLEEP);
	// Leaving a disconnecting action back to a live port, or sleep for report-disconnect, needs the controls checked
	wire logic chg_reeval = (old_disc && !new_disc)
		|| ((act_q == ACT_DISC_SLEEP) && (act_d == ACT_RPT_DISC));
	wire logic limit_d = (state_d == ST_LIMIT);

	////////////////////////////////////////////////////////////////////////
	// Next state and accumulator; disable beats reset beats action change
	always_comb begin
		state_d = state_q;
		acc_d = acc_q;
		reeval = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (rst_req_q) begin
					acc_d = ACC_ZERO;
				end
				if (en_q && !disable_ev) begin
					state_d = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (disable_ev) begin
					state_d = ST_IDLE;
					acc_d = ACC_ZERO;
				end else if (rst_req_q) begin
					acc_d = ACC_ZERO;
				end else if (reached_now) begin
					state_d = ST_LIMIT;
				end else if (in_active_state && charge_valid) begin
					acc_d = acc_sat;
				end
			end
			ST_LIMIT: begin
				if (disable_ev) begin
					state_d = ST_IDLE;
					reeval = 1'b1;
					if (rst_req_q) begin
						acc_d = ACC_ZERO;
					end
				end else if (rst_req_q) begin
					state_d = ST_COUNT;
					acc_d = ACC_ZERO;
					reeval = old_disc;
				end else if (act_chg) begin
					reeval = chg_reeval;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Removal followed by attach below the limit restarts emulation; count unaffected
	always_comb begin
		removal_seen_d = removal_seen_q;
		if (!in_count) begin
			removal_seen_d = 1'b0;
		end else if (removal_event) begin
			removal_seen_d = 1'b1;
		end else if (attach_event) begin
			removal_seen_d = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_IDLE;
			acc_q <= ACC_ZERO;
			removal_seen_q <= 1'b0;
		end else begin
			state_q <= state_d;
			acc_q <= acc_d;
			removal_seen_q <= removal_seen_d;
		end
	end

	// Control register; the reset request lasts one cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			en_q <= 1'b0;
			act_q <= ACT_RESET;
			rst_req_q <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				en_q <= new_en;
				act_q <= new_act;
			end
			rst_req_q <= rst_wr;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			limit_q <= LIMIT_RESET;
		end else if (limit_wr) begin
			limit_q <= reg_wdata[CHG_W-1:0];
		end
	end

	// Controls seen at the threshold, compared when re-evaluating
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			snap_q <= '0;
		end else if (in_count && (state_d == ST_LIMIT)) begin
			snap_q <= ctrl_vec;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs follow the action in force while the limit holds
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			alert_q <= 1'b0;
			open_q <= 1'b0;
			sleep_q <= 1'b0;
			emu_rm_q <= 1'b0;
		end else begin
			alert_q <= limit_d && ((act_d == ACT_REPORT) || (act_d == ACT_RPT_DISC));
			open_q <= limit_d && new_disc;
			sleep_q <= limit_d && (act_d == ACT_DISC_SLEEP);
			emu_rm_q <= limit_d && new_disc;
		end
	end

	// Unchanged controls resume the old state with no discharge or restart
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			enter_q <= 1'b0;
			resume_q <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			enter_q <= reeval && ctrl_changed;
			resume_q <= reeval && !ctrl_changed;
			restart_q <= (reeval && ctrl_changed && emulation_enable)
				|| (in_count && removal_seen_q && attach_event);
		end
	end

	////////////////////////////////////////////////////////////////////////
	wire logic [DATA_W-1:0] ctrl_rd = {{(DATA_W-4){1'b0}}, act_q, 1'b0, en_q};
	wire logic [DATA_W-1:0] limit_rd = {{(DATA_W-CHG_W){1'b0}}, limit_q};
	wire logic [DATA_W-1:0] acc_rd = {{(DATA_W-CHG_W){1'b0}}, acc_q};
	wire logic [DATA_W-1:0] stat_rd = {{(DATA_W-5){1'b0}}, emu_rm_q, sleep_q, open_q,
		alert_q, in_limit};
	wire logic [DATA_W-1:0] rd_mux = (reg_addr == OFF_CTRL) ? ctrl_rd :
		(reg_addr == OFF_LIMIT) ? limit_rd :
		(reg_addr == OFF_ACCUM) ? acc_rd :
		(reg_addr == OFF_STATUS) ? stat_rd : '0;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			rdata_q <= rd_mux;
		end
	end

	assign reg_rdata = rdata_q;
	// Open drain: pin pulled low only while alerting
	assign alert_out = 1'b0;
	assign alert_oe_n = !alert_q;
	assign power_switch_force_open = open_q;
	assign bypass_force_open = open_q;
	assign emulation_remove = emu_rm_q;
	assign sleep_request = sleep_q;
	assign reeval_enter_pulse = enter_q;
	assign reeval_resume_pulse = resume_q;
	assign emulation_restart_pulse = restart_q;

	////////////////////////////////////////////////////////////////////////
	AST_ACC_ONLY_ACTIVE: assert property (@(posedge sys_clk) disable iff (!nrst)
		!in_active_state |=> (acc_q == $past(acc_q)) || (acc_q == ACC_ZERO))
		else $error("Charge accumulated outside Active state");

	AST_REACH_SETS_FLAG: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_count && reached_now && !ctrl_wr && !rst_req_q |=> in_limit
			&& (alert_q == ((act_q == ACT_REPORT) || (act_q == ACT_RPT_DISC)))
			&& (open_q == ((act_q == ACT_RPT_DISC) || (act_q == ACT_DISC_SLEEP))))
		else $error("Threshold not taken or wrong switch action");

	AST_RST_SELF_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst)
		rst_wr ##1 !rst_wr |=> !rst_req_q && (acc_q == ACC_ZERO))
		else $error("Reset request did not clear charge or itself");

	AST_DISABLE_BELOW: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_count && disable_ev |=> in_idle && (acc_q == ACC_ZERO))
		else $error("Disable below limit kept charge");

	AST_DISABLE_AFTER: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_limit && disable_ev |=> !in_limit && !alert_q && (enter_q || resume_q))
		else $error("Disable after limit not handled");

	AST_ACT_KEEPS_ACC: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_limit && act_chg && !rst_req_q |=> $stable(acc_q))
		else $error("Action change disturbed accumulated charge");

	AST_SLEEP_OPENS: assert property (@(posedge sys_clk) disable iff (!nrst)
		sleep_request |-> power_switch_force_open && emulation_remove && !alert_q)
		else $error("Sleep without open switch or with alert");

	AST_REMOVE_ATTACH: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_count && removal_seen_q && attach_event |=> emulation_restart_pulse)
		else $error("Emulation not restarted after removal and attach");

	AST_REPORT_ALERT: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_limit && act_chg && (new_act == ACT_REPORT) && !rst_req_q |=> alert_q && !open_q)
		else $error("Change to report after limit not applied at once");

	AST_RESET_REEVAL: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_limit && rst_req_q && !disable_ev && old_disc |=> (enter_q || resume_q) && !in_limit)
		else $error("Reset after disconnecting action did not re-evaluate");

	AST_QUIET_BELOW: assert property (@(posedge sys_clk) disable iff (!nrst)
		!in_limit |-> alert_oe_n && !power_switch_force_open
			&& !emulation_remove && !sleep_request)
		else $error("Rationing output active below the threshold");

	AST_COUNT_ADDS: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_count && in_active_state && charge_valid && !reached_now && !disable_ev
			&& !rst_req_q |=> (acc_q == $past(acc_q) + $past(charge_amount))
			|| (acc_q == {CHG_W{1'b1}}))
		else $error("Charge not added in Active state");

	AST_COUNT_ACT_KEEPS: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_count && act_chg && !rst_req_q && !(in_active_state && charge_valid)
			|=> $stable(acc_q))
		else $error("Action change below limit disturbed charge");

	AST_EVENT_KEEPS_ACC: assert property (@(posedge sys_clk) disable iff (!nrst)
		(attach_event || removal_event) && !ctrl_wr && !rst_req_q
			&& !(in_active_state && charge_valid) |=> $stable(acc_q))
		else $error("Detection event disturbed charge");

	AST_RST_ZEROES_BELOW: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_count && rst_req_q && !disable_ev |=> in_count && (acc_q == ACC_ZERO))
		else $error("Reset request below limit did not restart from zero");

	AST_RST_AFTER_FREES: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_limit && rst_req_q && !disable_ev
			|=> in_count && alert_oe_n && !power_switch_force_open)
		else $error("Reset after limit kept alert or switch");

	AST_CHG_BEFORE_SILENT: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_count && act_chg && !reached_now && !rst_req_q |=> !in_limit && alert_oe_n)
		else $error("Action change below limit had a visible step");

	AST_TO_IGNORE: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_limit && act_chg && (new_act == ACT_IGNORE) && !rst_req_q
			|=> in_limit && alert_oe_n && !power_switch_force_open && !sleep_request)
		else $error("Change to ignore after limit not applied");

	AST_TO_RPT_DISC: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_limit && act_chg && (new_act == ACT_RPT_DISC) && !rst_req_q
			|=> !alert_oe_n && power_switch_force_open && emulation_remove && !sleep_request)
		else $error("Change to report and disconnect not applied");

	AST_TO_SLEEP: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_limit && act_chg && (new_act == ACT_DISC_SLEEP) && !rst_req_q
			|=> sleep_request && alert_oe_n && power_switch_force_open)
		else $error("Change to disconnect and sleep not applied");

	AST_SLEEP_TO_RPT_DISC: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_limit && act_chg && (act_q == ACT_DISC_SLEEP) && (new_act == ACT_RPT_DISC)
			&& !rst_req_q |=> bypass_force_open && power_switch_force_open
			&& !alert_oe_n && (reeval_enter_pulse || reeval_resume_pulse))
		else $error("Leaving sleep closed a switch or skipped re-evaluation");

	AST_RESUME_NO_RESTART: assert property (@(posedge sys_clk) disable iff (!nrst)
		reeval_resume_pulse |-> !emulation_restart_pulse && !reeval_enter_pulse)
		else $error("Resume restarted emulation");

	AST_ENTER_RESTARTS: assert property (@(posedge sys_clk) disable iff (!nrst)
		reeval_enter_pulse && $past(emulation_enable) |-> emulation_restart_pulse)
		else $error("Changed controls did not restart emulation");

	AST_IDLE_HOLDS_ACC: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_idle && !rst_req_q |=> $stable(acc_q))
		else $error("Charge moved while rationing disabled");

	AST_LIMIT_HOLDS_ACC: assert property (@(posedge sys_clk) disable iff (!nrst)
		in_limit && !rst_req_q |=> $stable(acc_q))
		else $error("Charge moved after the threshold");

endmodule

`default_nettype wire

// ===== hdl/crc_pkg.sv
// Constants for the charge rationing control block.
// Assumes a plain register port with 32-bit data and one 25 MHz clock.
// Notes on behaviour
// - Rationing_reached_flag and accumulate only in Active state; the code sets the flag on reaching the limit in any power state
// - Below threshold, run normally for any action
// - Attach or removal never resets rationing
// - Removal then attach below limit restarts emulation
// - Action change leaves accumulated charge intact
// - Change before limit is silent until reached
// - Change after limit applies new action at once
// - From ignore: alert, disconnect or sleep steps
// - From report: release, open switch or sleep
// - From report-disconnect: release, re-evaluate or sleep
// - From sleep: re-evaluate, alert, keep switches open
// - Re-evaluate: changed controls enter state, else resume
// - Enable cleared below limit clears accumulated charge
// - Enable cleared after limit: clear flag, release, re-evaluate
// - Reset request zeroes charge, accumulation restarts
// - Reset after limit follows the selected action
// - Reset clears flag, releases alert, maybe re-evaluates
// - Action codes 00 rep, 01 rep-disc, 10 sleep, 11 ignore

package crc_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CHG_W = 16;
	localparam int CTRL_W = 5;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_LIMIT = 8'h04;
	localparam logic [7:0] OFF_ACCUM = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;

	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_RST_BIT = 1;
	localparam int CTRL_ACT_LSB = 2;

	localparam int ST_REACHED_BIT = 0;
	localparam int ST_ALERT_BIT = 1;
	localparam int ST_OPEN_BIT = 2;
	localparam int ST_SLEEP_BIT = 3;
	localparam int ST_EMU_BIT = 4;

	////////////////////////////////////////////////////////////////////////
	localparam logic [1:0] ACT_REPORT = 2'h0;
	localparam logic [1:0] ACT_RPT_DISC = 2'h1;
	localparam logic [1:0] ACT_DISC_SLEEP = 2'h2;
	localparam logic [1:0] ACT_IGNORE = 2'h3;

	localparam logic [1:0] ACT_RESET = ACT_RPT_DISC;
	localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
	localparam logic [15:0] ACC_ZERO = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_COUNT = 3'b010,
		ST_LIMIT = 3'b100
	} crc_state_t;

endpackage
